// ---- pkg/cai_pkg.sv ----
// Constants and types for the compact add-immediate unit.
// Assumes a core that presents one 16-bit instruction halfword per cycle.

package cai_pkg;

  // ----------------------------------------------------------------
  // Major opcodes and fixed fields
  // ----------------------------------------------------------------
  localparam logic [4:0] EXT_PREFIX_OP = 5'h1e;
  localparam logic [4:0] ADD_IMM8_MAJOR_OP = 5'h09;
  localparam logic [4:0] REG_REG_IMM_ADD_MAJOR_OP = 5'h08;
  localparam logic [4:0] PC_ADD_MAJOR_OP = 5'h01;
  localparam logic [2:0] ZERO_FIELD = 3'h0;

  // ----------------------------------------------------------------
  // Field positions in a halfword
  // ----------------------------------------------------------------
  localparam int MAJOR_MSB = 15;
  localparam int MAJOR_LSB = 11;
  localparam int RX_MSB = 10;
  localparam int RX_LSB = 8;
  localparam int SECOND_REG_MSB = 7;
  localparam int SECOND_REG_LSB = 5;
  localparam int ADD_SEL_BIT = 4;

  // ----------------------------------------------------------------
  // Register translation and timing
  // ----------------------------------------------------------------
  localparam logic [4:0] XLAT_HIGH_BASE = 5'h10;
  localparam logic [2:0] XLAT_DIRECT_MIN = 3'h2;
  localparam int RESULT_LATENCY = 1;
  localparam int WORD_WIDTH = 32;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    CAI_IDLE = 1'b0,
    CAI_PREFIX = 1'b1
  } cai_state_t;

  typedef enum logic [2:0] {
    CAI_FORM_NONE = 3'b000,
    CAI_FORM_EXT2 = 3'b001,
    CAI_FORM_RRI = 3'b010,
    CAI_FORM_RRI_EXT = 3'b011,
    CAI_FORM_PC = 3'b100,
    CAI_FORM_PC_EXT = 3'b101
  } cai_form_t;

endpackage

// ---- hw/cai_xlat.sv ----
// Translation of a 3-bit register field to a physical register index.
// Assumes a 32-entry general register file.

`timescale 1ns/1ns

module cai_xlat
  import cai_pkg::*;
(
  // Field in
  input wire logic [2:0] field,
  // Index out
  output logic [4:0] phys_idx
);

  // ----------------------------------------------------------------
  // Translation
  // ----------------------------------------------------------------
  always_comb begin
    if (field < XLAT_DIRECT_MIN) begin
      phys_idx = XLAT_HIGH_BASE | {2'h0, field};
    end else begin
      phys_idx = {2'h0, field};
    end
  end

endmodule // cai_xlat

// ---- hw/cai_unit.sv ----
// Decode and execute logic for the compact add-immediate word family.
// Assumes halfwords arrive in program order with their addresses, and that the
// register file answers a read index with data in the same cycle.

`timescale 1ns/1ns

module cai_unit
  import cai_pkg::*;
#(
  parameter int XLEN = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Instruction halfword stream
  input wire logic hw_valid,
  input wire logic [15:0] hw_data,
  input wire logic [XLEN-1:0] hw_addr,
  input wire logic in_delay_slot,
  input wire logic [XLEN-1:0] jump_addr,
  // Register read port
  output logic [4:0] rd_idx,
  input wire logic [XLEN-1:0] rd_data,
  // Register write port
  output logic wr_en,
  output logic [4:0] wr_idx,
  output logic [XLEN-1:0] wr_data,
  // Status
  output logic unpredictable,
  output logic prefix_pending
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (XLEN <= WORD_WIDTH) begin : g_bad_xlen
    $error("cai_unit: XLEN must exceed 32");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cai_state_t state_q;
  cai_state_t state_d;
  logic [15:0] prefix_q;
  logic [15:0] prefix_d;
  logic [XLEN-1:0] prefix_addr_q;
  logic [XLEN-1:0] prefix_addr_d;
  logic wr_en_q;
  logic wr_en_d;
  logic [4:0] wr_idx_q;
  logic [4:0] wr_idx_d;
  logic [XLEN-1:0] wr_data_q;
  logic [XLEN-1:0] wr_data_d;
  logic unpred_q;
  logic unpred_d;
  cai_form_t form;
  logic [4:0] major;
  logic [4:0] rx_idx;
  logic [4:0] second_reg_idx;
  logic [15:0] imm16;
  logic [14:0] imm15;
  logic [XLEN-1:0] base_pc;
  logic [XLEN-1:0] operand;
  logic [XLEN-1:0] addend;
  logic [XLEN-1:0] sum;
  logic [4:0] dest_idx;
  logic check_fail;

  function automatic logic not_word_check(input logic [XLEN-1:0] val);
    not_word_check = !((&val[XLEN-1:WORD_WIDTH-1]) || !(|val[XLEN-1:WORD_WIDTH-1]));
  endfunction

  // ----------------------------------------------------------------
  // Register field translation
  // ----------------------------------------------------------------
  cai_xlat u_xlat_rx (
    .field(hw_data[RX_MSB:RX_LSB]),
    .phys_idx(rx_idx)
  );

  cai_xlat u_xlat_second (
    .field(hw_data[SECOND_REG_MSB:SECOND_REG_LSB]),
    .phys_idx(second_reg_idx)
  );

  assign major = hw_data[MAJOR_MSB:MAJOR_LSB];
  assign rd_idx = rx_idx;

  // ----------------------------------------------------------------
  // Prefix tracking
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    prefix_d = prefix_q;
    prefix_addr_d = prefix_addr_q;
    if (hw_valid) begin
      if (major == EXT_PREFIX_OP) begin
        state_d = CAI_PREFIX;
        prefix_d = hw_data;
        prefix_addr_d = hw_addr;
      end else begin
        state_d = CAI_IDLE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= CAI_IDLE;
      prefix_q <= 16'h0000;
      prefix_addr_q <= '0;
    end else begin
      state_q <= state_d;
      prefix_q <= prefix_d;
      prefix_addr_q <= prefix_addr_d;
    end
  end

  // ----------------------------------------------------------------
  // Form decode
  // ----------------------------------------------------------------
  always_comb begin
    form = CAI_FORM_NONE;
    if (hw_valid && major != EXT_PREFIX_OP) begin
      if (state_q == CAI_PREFIX) begin
        if (major == ADD_IMM8_MAJOR_OP && hw_data[SECOND_REG_MSB:SECOND_REG_LSB] == ZERO_FIELD) begin
          form = CAI_FORM_EXT2;
        end else if (major == REG_REG_IMM_ADD_MAJOR_OP && !hw_data[ADD_SEL_BIT]) begin
          form = CAI_FORM_RRI_EXT;
        end else if (major == PC_ADD_MAJOR_OP && hw_data[SECOND_REG_MSB:SECOND_REG_LSB] == ZERO_FIELD) begin
          form = CAI_FORM_PC_EXT;
        end
      end else begin
        if (major == REG_REG_IMM_ADD_MAJOR_OP && !hw_data[ADD_SEL_BIT]) begin
          form = CAI_FORM_RRI;
        end else if (major == PC_ADD_MAJOR_OP) begin
          form = CAI_FORM_PC;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Immediate reassembly and operand selection
  // ----------------------------------------------------------------
  assign imm16 = {prefix_q[4:0], prefix_q[10:5], hw_data[4:0]};
  assign imm15 = {prefix_q[3:0], prefix_q[10:4], hw_data[3:0]};

  always_comb begin
    base_pc = in_delay_slot ? jump_addr : hw_addr;
    operand = rd_data;
    addend = '0;
    dest_idx = rx_idx;
    check_fail = not_word_check(rd_data);
    unique case (form)
      CAI_FORM_EXT2: begin
        addend = {{(XLEN-16){imm16[15]}}, imm16};
      end
      CAI_FORM_RRI: begin
        addend = {{(XLEN-4){hw_data[3]}}, hw_data[3:0]};
        dest_idx = second_reg_idx;
      end
      CAI_FORM_RRI_EXT: begin
        addend = {{(XLEN-15){imm15[14]}}, imm15};
        dest_idx = second_reg_idx;
      end
      CAI_FORM_PC: begin
        operand = {base_pc[XLEN-1:2], 2'b00};
        addend = {{(XLEN-10){1'b0}}, hw_data[7:0], 2'b00};
        check_fail = not_word_check(base_pc);
      end
      CAI_FORM_PC_EXT: begin
        operand = {prefix_addr_q[XLEN-1:2], 2'b00};
        addend = {{(XLEN-16){imm16[15]}}, imm16};
        check_fail = not_word_check(prefix_addr_q);
      end
      default: begin
        check_fail = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Add and write-back
  // ----------------------------------------------------------------
  assign sum = operand + addend;

  always_comb begin
    wr_en_d = (form != CAI_FORM_NONE);
    wr_idx_d = dest_idx;
    wr_data_d = {{(XLEN-WORD_WIDTH){sum[WORD_WIDTH-1]}}, sum[WORD_WIDTH-1:0]};
    unpred_d = (form != CAI_FORM_NONE) && check_fail;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_en_q <= 1'b0;
      wr_idx_q <= 5'h00;
      wr_data_q <= '0;
      unpred_q <= 1'b0;
    end else begin
      wr_en_q <= wr_en_d;
      wr_idx_q <= wr_idx_d;
      wr_data_q <= wr_data_d;
      unpred_q <= unpred_d;
    end
  end

  assign wr_en = wr_en_q;
  assign wr_idx = wr_idx_q;
  assign wr_data = wr_data_q;
  assign unpredictable = unpred_q;
  assign prefix_pending = (state_q == CAI_PREFIX);

endmodule // cai_unit

// ---- verification/cai_unit_props.sv ----
// Assertions on the ports of the compact add-immediate unit.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module cai_unit_props
  import cai_pkg::*;
#(
  parameter int XLEN = 64
) (
  // Clock, reset and request
  input wire logic clk,
  input wire logic reset,
  input wire logic hw_valid,
  input wire logic [15:0] hw_data,
  input wire logic [XLEN-1:0] rd_data,
  // Results
  input wire logic [4:0] rd_idx,
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [XLEN-1:0] wr_data,
  input wire logic unpredictable,
  input wire logic prefix_pending
);
  // ----------------------------------------------------------------
  // Helpers and properties
  // ----------------------------------------------------------------
  logic [4:0] op;
  logic [4:0] second_reg_phys;
  logic rri;
  assign op = hw_data[15:11];
  assign second_reg_phys = (hw_data[7:6] == 2'h0) ? {4'h8, hw_data[5]} : {2'h0, hw_data[7:5]};
  assign rri = hw_valid && op == REG_REG_IMM_ADD_MAJOR_OP && !hw_data[ADD_SEL_BIT];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  chk_xlat_map:
    assert property (rd_idx == ((hw_data[10:9] == 2'h0) ? {4'h8, hw_data[8]} : {2'h0, hw_data[10:8]}))
    else $error("read index wrong");
  chk_rri_dest:
    assert property (rri && !prefix_pending |=> wr_en && wr_idx == $past(second_reg_phys)) else $error("plain dest wrong");
  chk_ext_rri:
    assert property (rri && prefix_pending |=> wr_en && wr_idx == $past(second_reg_phys) && !prefix_pending)
    else $error("extended dest wrong");
  chk_ext2_dest:
    assert property (hw_valid && prefix_pending && op == ADD_IMM8_MAJOR_OP && hw_data[7:5] == ZERO_FIELD
      |=> wr_en && wr_idx == $past(rd_idx)) else $error("two-operand dest wrong");
  chk_prefix_hold:
    assert property (hw_valid && op == EXT_PREFIX_OP |=> prefix_pending && !wr_en) else $error("prefix not held");
  chk_pc_plain:
    assert property (hw_valid && !prefix_pending && op == PC_ADD_MAJOR_OP
      |=> wr_en && wr_idx == $past(rd_idx) && wr_data[1:0] == 2'h0) else $error("pc form wrong");
  chk_word_sext:
    assert property (wr_en |-> wr_data[XLEN-1:31] == '0 || wr_data[XLEN-1:31] == '1) else $error("not sign-extended");
  chk_no_request:
    assert property (!hw_valid |=> !wr_en) else $error("write without request");
  chk_sel_bit:
    assert property (hw_valid && op == REG_REG_IMM_ADD_MAJOR_OP && hw_data[4] |=> !wr_en) else $error("bit4 ignored");
  chk_non_word:
    assert property (rri && rd_data[XLEN-1:31] != '0 && rd_data[XLEN-1:31] != '1 |=> unpredictable && wr_en)
    else $error("flag missing");
endmodule // cai_unit_props

bind cai_unit cai_unit_props #(.XLEN(XLEN)) u_props (.clk(clk), .reset(reset), .hw_valid(hw_valid),
  .hw_data(hw_data), .rd_data(rd_data), .rd_idx(rd_idx), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data),
  .unpredictable(unpredictable), .prefix_pending(prefix_pending));

// ---- verification/test_compact_add_immediate_unit.sv ----
// Self-checking bench for the compact add-immediate unit.
// Assumes a one-cycle answer and same-cycle register read data.
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; $display("ERROR %0t %h %h", $time, a, b); end end
module test_compact_add_immediate_unit
  import cai_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and scenarios
  // ----------------------------------------------------------------
  logic clk = 1'b0, reset = 1'b1, hw_valid = 1'b0, in_delay_slot = 1'b0;
  logic [15:0] hw_data = 16'h0;
  logic [63:0] hw_addr = 64'h0, jump_addr = 64'h0, rd_data = 64'h0, wr_data;
  logic [4:0] rd_idx, wr_idx;
  logic wr_en, unpredictable, prefix_pending;
  int n_mismatch = 0, checks = 0, cyc = 0;
  cai_unit u_dut (.clk(clk), .reset(reset), .hw_valid(hw_valid), .hw_data(hw_data), .hw_addr(hw_addr),
    .in_delay_slot(in_delay_slot), .jump_addr(jump_addr), .rd_idx(rd_idx), .rd_data(rd_data), .wr_en(wr_en),
    .wr_idx(wr_idx), .wr_data(wr_data), .unpredictable(unpredictable), .prefix_pending(prefix_pending));
  function automatic logic [4:0] xl(input logic [2:0] f);
    return (f < 3'h2) ? {2'h2, f} : {2'h0, f};
  endfunction
  function automatic logic [63:0] sx(input logic [31:0] v);
    return {{32{v[31]}}, v};
  endfunction
  task automatic step(input logic [15:0] d, input logic [63:0] a, input logic [63:0] r);
    hw_valid = 1'b1;
    hw_data = d;
    hw_addr = a;
    rd_data = r;
    @(posedge clk);
    #1;
  endtask
  task automatic idle;
    hw_valid = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic t_rri;
    logic [3:0] imm;
    for (int i = 0; i < 8; i++) begin
      imm = {i[2:0], 1'b1};
      step({5'h08, 3'h2, i[2:0], 1'b0, imm}, 64'h0, 64'hffffffff_80000000);
      `CHK(wr_idx, xl(i[2:0]))
      `CHK(wr_data, sx(32'h80000000 + {{28{imm[3]}}, imm}))
      `CHK({wr_en, unpredictable}, 2'h2)
    end
    step(16'h4371, 64'h0, 64'h0);
    `CHK(wr_en, 1'b0)
    step(16'h4361, 64'h0, 64'h80000000);
    `CHK(unpredictable, 1'b1)
    `CHK(wr_data, sx(32'h80000001))
    idle;
  endtask
  task automatic t_ext;
    step({5'h1e, 7'h00, 4'h8}, 64'h0, 64'h0);
    `CHK(prefix_pending, 1'b1)
    idle;
    step({5'h08, 3'h4, 3'h1, 1'b0, 4'h1}, 64'h0, 64'h10);
    `CHK(wr_idx, 5'h11)
    `CHK(wr_data, sx(32'h10 + 32'hffffc001))
    step({5'h1e, 6'h00, 5'h10}, 64'h0, 64'h0);
    step({5'h09, 3'h5, 3'h0, 5'h03}, 64'h0, 64'h7fffffff);
    `CHK(wr_idx, 5'h05)
    `CHK(wr_data, sx(32'h7fff8002))
    step({5'h1e, 6'h00, 5'h10}, 64'h0, 64'h0);
    step(16'he800, 64'h0, 64'h0);
    `CHK({wr_en, prefix_pending}, 2'h0)
    idle;
  endtask
  task automatic t_pc;
    step({5'h01, 3'h1, 8'hff}, 64'h1003, 64'h0);
    `CHK(wr_data, 64'h13fc)
    `CHK(rd_idx, 5'h11)
    in_delay_slot = 1'b1;
    jump_addr = 64'hffffffff_fffffffe;
    step({5'h01, 3'h7, 8'h01}, 64'h5000, 64'h0);
    `CHK(wr_data, 64'h0)
    in_delay_slot = 1'b0;
    step({5'h01, 3'h2, 8'h00}, 64'h80000000, 64'h0);
    `CHK(unpredictable, 1'b1)
    step({5'h1e, 6'h3f, 5'h1f}, 64'h2002, 64'h0);
    step({5'h01, 3'h3, 3'h0, 5'h1e}, 64'h2004, 64'h0);
    `CHK(wr_idx, 5'h03)
    `CHK(wr_data, 64'h1ffe)
    idle;
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      complete_run;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    `CHK(wr_en, 1'b0)
    t_rri;
    t_ext;
    t_pc;
    complete_run;
  end
endmodule // test_compact_add_immediate_unit
